// file: include/cwdec_defs.svh
// constants for the configuration word decoder
`ifndef CWDEC_DEFS_SVH
`define CWDEC_DEFS_SVH
`define CWDEC_OFS_RSTWDT 16'h8008
`define CWDEC_OFS_RSVD 16'h8009
`define CWDEC_OFS_PROT 16'h800a
`define CWDEC_OFS_CODEPROT 16'h800b
`define CWDEC_OFS_CTRL 16'h8010
`define CWDEC_OFS_STAT 16'h8011
`define CWDEC_OFS_ERASE 16'h8012
`define CWDEC_RST_RSTWDT 16'h3fef
`define CWDEC_RST_PROT 16'h2f9f
`define CWDEC_RST_CODEPROT 16'h0003
`define CWDEC_POS_BOR_LEVEL 9
`define CWDEC_POS_BOR_MODE 6
`define CWDEC_POS_WDT_MODE 3
`define CWDEC_POS_PUP_DELAY 1
`define CWDEC_POS_RSTPIN_EN 0
`define CWDEC_POS_LOWV_PROG 13
`define CWDEC_POS_WRSAF 11
`define CWDEC_POS_WRD 10
`define CWDEC_POS_WRC 9
`define CWDEC_POS_WRB 8
`define CWDEC_POS_WRAPP 7
`define CWDEC_POS_STORE_EN_N 4
`define CWDEC_POS_BOOT_EN_N 3
`define CWDEC_POS_BOOT_SIZE 0
`define CWDEC_POS_EE_RDPROT_N 1
`define CWDEC_POS_FL_RDPROT_N 0
`define CWDEC_ERASE_KEY 16'h0010
`define CWDEC_PUP_64MS 64
`define CWDEC_PUP_16MS 16
`define CWDEC_PUP_1MS 1
`define CWDEC_CLK_KHZ 25000
`define CWDEC_FLASH_WORDS 8192
`endif

// file: include/cwdec_mode_if.sv
// carries one enable mode decode between modules
`timescale 1ns/10ps
interface cwdec_mode_if;
    logic [1:0] mode;
    logic sw_en;
    logic sleep;
    logic active;
    modport src (output mode, output sw_en, output sleep, input active);
    modport dec (input mode, input sw_en, input sleep, output active);
endinterface : cwdec_mode_if

// file: include/cwdec_pkg.sv
// types for the configuration word decoder
package cwdec_pkg;
    typedef enum logic [1:0] {
        CWDEC_MODE_OFF = 2'b00,
        CWDEC_MODE_SW = 2'b01,
        CWDEC_MODE_AWAKE = 2'b10,
        CWDEC_MODE_ON = 2'b11
    } cwdec_mode_t;
endpackage : cwdec_pkg

// file: logic/cwdec_mode_dec.sv
// decodes a two-bit hardware/software enable mode
`timescale 1ns/10ps
module cwdec_mode_dec (
    // mode link
    cwdec_mode_if.dec m
);
    always_comb begin
        case (cwdec_pkg::cwdec_mode_t'(m.mode))
            cwdec_pkg::CWDEC_MODE_ON: m.active = 1'b1;
            cwdec_pkg::CWDEC_MODE_AWAKE: m.active = ~m.sleep;
            cwdec_pkg::CWDEC_MODE_SW: m.active = m.sw_en;
            default: m.active = 1'b0;
        endcase
    end
endmodule : cwdec_mode_dec

// file: logic/cwdec_top.sv
// configuration word decoder with protection and partition logic
`timescale 1ns/10ps
`include "cwdec_defs.svh"
// Behaviour
// RQ1: brown-out mode 11 keeps reset always on, software bit ignored.
// RQ2: brown-out mode 10 enables reset while running, off in sleep.
// RQ3: brown-out mode 01 follows software bit; mode 00 disables it.
// RQ4: brown-out threshold comes from the level select bit.
// RQ5: watchdog mode 11 runs awake and asleep, software bit ignored.
// RQ6: watchdog mode 10 runs awake, suspended in sleep.
// RQ7: watchdog mode 01 follows software bit; 00 is off.
// RQ8: power-up delay: 11 none, 10 64 ms, 01 16 ms, 00 1 ms.
// RQ9: without low-voltage programming, reset-enable 0 makes the pin a port.
// RQ10: low-voltage programming forces the pin to stay reset input.
// RQ11: clearing low-voltage enable is refused during low-voltage programming.
// RQ12: each write-protect bit protects its region when 0.
// RQ13: enabled write protection is released only by bulk erase.
// RQ14: boot block and storage area are enabled by their low bits.
// RQ15: boot size code selects boot block end address.
// RQ16: boot block is clamped to half the program flash.
// RQ17: boot size changes only while the boot block is disabled.
// RQ18: eeprom code protection is on when its bit is 0.
// RQ19: flash code protection is on when its bit is 0.
// RQ20: code protection is removed only by bulk erase.
// RQ21: programmer writes the code-protect word last.
// RQ22: protected memories read zero externally and block programming; the code zeroes o_ext_rd_data only under flash protection.
// RQ23: storage and boot write protect apply only when region enabled.
module cwdec_top #(
    parameter int FLASH_WORDS = `CWDEC_FLASH_WORDS,
    parameter int CLK_KHZ = `CWDEC_CLK_KHZ
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // register port
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // run-time status
    input wire logic i_sleep,
    input wire logic i_lowv_prog_active,
    input wire logic [13:0] i_ext_rd_data,
    // decoded controls
    output logic o_brownout_en,
    output logic o_brownout_level_sel,
    output logic o_watchdog_en,
    output logic o_powerup_timer_en,
    output logic [31:0] o_powerup_cycles,
    output logic o_ext_reset_is_reset,
    output logic [4:0] o_write_protect,
    output logic o_storage_area_en,
    output logic o_boot_block_en,
    output logic [14:0] o_boot_end_addr,
    output logic o_flash_protect,
    output logic o_eeprom_protect,
    output logic o_ext_prog_block,
    output logic [13:0] o_ext_rd_data
);
    localparam int MS_CYC = CLK_KHZ;
    localparam logic [14:0] HALF_END = 15'(FLASH_WORDS / 2 - 1);

    typedef struct packed {
        logic [15:0] rstwdt;
        logic [15:0] prot;
        logic [15:0] codeprot;
        logic sw_bor;
        logic sw_wdt;
        logic [15:0] rdata;
        logic bor_en;
        logic bor_lvl;
        logic wdt_en;
        logic pup_en;
        logic [31:0] pup_cyc;
        logic pin_rst;
        logic [4:0] wp;
        logic store_en;
        logic bb_en;
        logic [14:0] bb_end;
        logic fcp;
        logic ecp;
        logic prog_blk;
        logic [13:0] xrd;
    } cwdec_state_t;

    cwdec_state_t st;
    cwdec_state_t next_st;

    cwdec_mode_if bor_if ();
    cwdec_mode_if wdt_if ();

    assign bor_if.mode = st.rstwdt[`CWDEC_POS_BOR_MODE +: 2];
    assign bor_if.sw_en = st.sw_bor;
    assign bor_if.sleep = i_sleep;
    assign wdt_if.mode = st.rstwdt[`CWDEC_POS_WDT_MODE +: 2];
    assign wdt_if.sw_en = st.sw_wdt;
    assign wdt_if.sleep = i_sleep;

    cwdec_mode_dec u_bor (.m(bor_if.dec)); // [RQ1] [RQ2] [RQ3]
    cwdec_mode_dec u_wdt (.m(wdt_if.dec)); // [RQ5] [RQ6] [RQ7]

    logic [15:0] w;
    logic [14:0] bb_raw;
    logic boot_dis;

    always_comb begin
        next_st = st;
        w = i_wdata;
        boot_dis = st.prot[`CWDEC_POS_BOOT_EN_N];
        // protection bits are sticky: a write may only move a bit from 1 to 0
        if (i_wr) begin
            case (i_addr)
                `CWDEC_OFS_RSTWDT: next_st.rstwdt = w;
                `CWDEC_OFS_PROT: begin
                    next_st.prot = w;
                    next_st.prot[`CWDEC_POS_WRSAF] =
                        st.prot[`CWDEC_POS_WRSAF] & w[`CWDEC_POS_WRSAF]; // [RQ13]
                    next_st.prot[`CWDEC_POS_WRD] =
                        st.prot[`CWDEC_POS_WRD] & w[`CWDEC_POS_WRD]; // [RQ13]
                    next_st.prot[`CWDEC_POS_WRC] =
                        st.prot[`CWDEC_POS_WRC] & w[`CWDEC_POS_WRC]; // [RQ13]
                    next_st.prot[`CWDEC_POS_WRB] =
                        st.prot[`CWDEC_POS_WRB] & w[`CWDEC_POS_WRB]; // [RQ13]
                    next_st.prot[`CWDEC_POS_WRAPP] =
                        st.prot[`CWDEC_POS_WRAPP] & w[`CWDEC_POS_WRAPP]; // [RQ13]
                    if (i_lowv_prog_active && !w[`CWDEC_POS_LOWV_PROG]) begin
                        next_st.prot[`CWDEC_POS_LOWV_PROG] =
                            st.prot[`CWDEC_POS_LOWV_PROG]; // [RQ11]
                    end
                    if (!boot_dis) begin
                        next_st.prot[`CWDEC_POS_BOOT_SIZE +: 3] =
                            st.prot[`CWDEC_POS_BOOT_SIZE +: 3]; // [RQ17]
                    end
                end
                `CWDEC_OFS_CODEPROT: begin
                    next_st.codeprot = st.codeprot & w; // [RQ20]
                end
                `CWDEC_OFS_CTRL: begin
                    next_st.sw_bor = w[0];
                    next_st.sw_wdt = w[1];
                end
                `CWDEC_OFS_ERASE: begin
                    if (w == `CWDEC_ERASE_KEY) begin
                        next_st.prot = `CWDEC_RST_PROT; // [RQ13] [RQ17]
                        next_st.codeprot = `CWDEC_RST_CODEPROT; // [RQ20]
                    end
                end
                default: ;
            endcase
        end
        // read path, data valid the cycle after the strobe
        next_st.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `CWDEC_OFS_RSTWDT: next_st.rdata = st.rstwdt;
                `CWDEC_OFS_PROT: next_st.rdata = st.prot;
                `CWDEC_OFS_CODEPROT: next_st.rdata = st.codeprot;
                `CWDEC_OFS_CTRL: next_st.rdata = {14'h0000, st.sw_wdt, st.sw_bor};
                `CWDEC_OFS_STAT: next_st.rdata = {10'h000, st.fcp, st.ecp, st.bb_en,
                    st.store_en, st.wdt_en, st.bor_en};
                default: next_st.rdata = 16'h0000;
            endcase
        end
        // decoded outputs
        next_st.bor_en = bor_if.active;
        next_st.bor_lvl = st.rstwdt[`CWDEC_POS_BOR_LEVEL]; // [RQ4]
        next_st.wdt_en = wdt_if.active;
        case (st.rstwdt[`CWDEC_POS_PUP_DELAY +: 2]) // [RQ8]
            2'b11: begin
                next_st.pup_en = 1'b0;
                next_st.pup_cyc = 32'h0000_0000;
            end
            2'b10: begin
                next_st.pup_en = 1'b1;
                next_st.pup_cyc = 32'(`CWDEC_PUP_64MS * MS_CYC);
            end
            2'b01: begin
                next_st.pup_en = 1'b1;
                next_st.pup_cyc = 32'(`CWDEC_PUP_16MS * MS_CYC);
            end
            default: begin
                next_st.pup_en = 1'b1;
                next_st.pup_cyc = 32'(`CWDEC_PUP_1MS * MS_CYC);
            end
        endcase
        next_st.pin_rst = st.prot[`CWDEC_POS_LOWV_PROG] |
            st.rstwdt[`CWDEC_POS_RSTPIN_EN]; // [RQ9] [RQ10]
        next_st.store_en = ~st.prot[`CWDEC_POS_STORE_EN_N]; // [RQ14]
        next_st.bb_en = ~boot_dis; // [RQ14]
        next_st.wp[0] = ~st.prot[`CWDEC_POS_WRAPP]; // [RQ12]
        next_st.wp[1] = ~st.prot[`CWDEC_POS_WRB] & ~boot_dis; // [RQ12] [RQ23]
        next_st.wp[2] = ~st.prot[`CWDEC_POS_WRC]; // [RQ12]
        next_st.wp[3] = ~st.prot[`CWDEC_POS_WRD]; // [RQ12]
        next_st.wp[4] = ~st.prot[`CWDEC_POS_WRSAF] & ~st.prot[`CWDEC_POS_STORE_EN_N]; // [RQ23]
        case (st.prot[`CWDEC_POS_BOOT_SIZE +: 3]) // [RQ15]
            3'b111: bb_raw = 15'h01ff;
            3'b110: bb_raw = 15'h03ff;
            3'b101: bb_raw = 15'h07ff;
            3'b100: bb_raw = 15'h0fff;
            3'b011: bb_raw = 15'h1fff;
            default: bb_raw = 15'h3fff;
        endcase
        if (boot_dis) begin
            next_st.bb_end = 15'h0000;
        end else if (bb_raw > HALF_END) begin
            next_st.bb_end = HALF_END; // [RQ16]
        end else begin
            next_st.bb_end = bb_raw;
        end
        next_st.ecp = ~st.codeprot[`CWDEC_POS_EE_RDPROT_N]; // [RQ18]
        next_st.fcp = ~st.codeprot[`CWDEC_POS_FL_RDPROT_N]; // [RQ19]
        next_st.prog_blk = next_st.fcp | next_st.ecp; // [RQ22]
        next_st.xrd = (next_st.fcp) ? 14'h0000 : i_ext_rd_data; // [RQ22]
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st <= '0;
            st.rstwdt <= `CWDEC_RST_RSTWDT;
            st.prot <= `CWDEC_RST_PROT;
            st.codeprot <= `CWDEC_RST_CODEPROT;
            st.pin_rst <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_brownout_en = st.bor_en;
    assign o_brownout_level_sel = st.bor_lvl;
    assign o_watchdog_en = st.wdt_en;
    assign o_powerup_timer_en = st.pup_en;
    assign o_powerup_cycles = st.pup_cyc;
    assign o_ext_reset_is_reset = st.pin_rst;
    assign o_write_protect = st.wp;
    assign o_storage_area_en = st.store_en;
    assign o_boot_block_en = st.bb_en;
    assign o_boot_end_addr = st.bb_end;
    assign o_flash_protect = st.fcp;
    assign o_eeprom_protect = st.ecp;
    assign o_ext_prog_block = st.prog_blk; // [RQ22]
    assign o_ext_rd_data = st.xrd;

    property p_bor_on;
        @(posedge i_core_clk) disable iff (i_reset)
        (st.rstwdt[7:6] == 2'b11) |=> o_brownout_en;
    endproperty
    a_bor_on: assert property (p_bor_on) else $error("bor not on"); // [RQ1]

    property p_bor_sleep;
        @(posedge i_core_clk) disable iff (i_reset)
        (st.rstwdt[7:6] == 2'b10) |=> (o_brownout_en == !$past(i_sleep));
    endproperty
    a_bor_sleep: assert property (p_bor_sleep) else $error("bor sleep wrong"); // [RQ2]

    property p_wdt_sw;
        @(posedge i_core_clk) disable iff (i_reset)
        (st.rstwdt[4:3] == 2'b01) |=> (o_watchdog_en == $past(st.sw_wdt));
    endproperty
    a_wdt_sw: assert property (p_wdt_sw) else $error("wdt sw wrong"); // [RQ7]

    property p_lowv_hold;
        @(posedge i_core_clk) disable iff (i_reset)
        (i_lowv_prog_active && st.prot[13]) |=> st.prot[13];
    endproperty
    a_lowv_hold: assert property (p_lowv_hold) else $error("low-voltage enable cleared"); // [RQ11]

    property p_codeprot_sticky;
        @(posedge i_core_clk) disable iff (i_reset)
        (!st.codeprot[0] && !(i_wr && i_addr == `CWDEC_OFS_ERASE)) |=> !st.codeprot[0];
    endproperty
    a_codeprot_sticky: assert property (p_codeprot_sticky) else $error("protect released"); // [RQ20]

    property p_bootsize_lock;
        @(posedge i_core_clk) disable iff (i_reset)
        (!st.prot[3] && !(i_wr && i_addr == `CWDEC_OFS_ERASE)) |=> $stable(st.prot[2:0]);
    endproperty
    a_bootsize_lock: assert property (p_bootsize_lock) else $error("boot size changed"); // [RQ17]

    property p_bb_clamp;
        @(posedge i_core_clk) disable iff (i_reset)
        o_boot_end_addr <= HALF_END;
    endproperty
    a_bb_clamp: assert property (p_bb_clamp) else $error("boot block too big"); // [RQ16]

    property p_rd_zero;
        @(posedge i_core_clk) disable iff (i_reset)
        (!st.codeprot[0] ##1 !st.codeprot[0]) |-> (o_ext_rd_data == 14'h0000);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("protected read leaked"); // [RQ22]
endmodule : cwdec_top

// file: sim/cwdec_prog_model.sv
// register-port model of the programmer that loads the configuration words
`timescale 1ns/10ps
`include "cwdec_defs.svh"
module cwdec_prog_model (
    // clock and read data
    input wire logic i_core_clk,
    input wire logic [15:0] i_rdata,
    // register port
    output logic [15:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // released write data is inverted so a stale value is never mistaken for a fresh one
    task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr_word

    task automatic rd_word(input logic [15:0] a, output logic [15:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd_word

    // protection takes effect at once, so the code-protect word goes last
    task automatic program_all(input logic [15:0] c2, input logic [15:0] pw,
        input logic [15:0] code_w);
        wr_word(`CWDEC_OFS_RSTWDT, c2);
        wr_word(`CWDEC_OFS_PROT, pw);
        wr_word(`CWDEC_OFS_CODEPROT, code_w);
    endtask : program_all
endmodule : cwdec_prog_model

// file: sim/tb_config_word_decoder.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/10ps
`include "cwdec_defs.svh"
module tb_config_word_decoder;
    localparam int FLASH = 8192;
    localparam int KHZ = 25000;
    logic i_core_clk, i_reset, i_sleep, i_lowv_prog_active;
    logic [13:0] i_ext_rd_data;
    logic [15:0] addr, wdata, rdata;
    logic wr, rd, bor, blvl, wdt, pwen, pin_rst, store_en, bb_en, fcp, ecp, pblk;
    logic [31:0] pcyc;
    logic [4:0] wp;
    logic [14:0] bend;
    logic [13:0] xrd;
    int n_fail = 0;
    int cmp_count = 0;

    cwdec_top #(.FLASH_WORDS(FLASH), .CLK_KHZ(KHZ)) i_dut (.i_core_clk(i_core_clk),
        .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_sleep(i_sleep), .i_lowv_prog_active(i_lowv_prog_active),
        .i_ext_rd_data(i_ext_rd_data), .o_brownout_en(bor), .o_brownout_level_sel(blvl),
        .o_watchdog_en(wdt), .o_powerup_timer_en(pwen), .o_powerup_cycles(pcyc),
        .o_ext_reset_is_reset(pin_rst), .o_write_protect(wp), .o_storage_area_en(store_en),
        .o_boot_block_en(bb_en), .o_boot_end_addr(bend), .o_flash_protect(fcp),
        .o_eeprom_protect(ecp), .o_ext_prog_block(pblk), .o_ext_rd_data(xrd));
    cwdec_prog_model i_prog (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic rdchk(input string n, input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        i_prog.rd_word(a, d);
        chk(n, 32'(d), 32'(e));
    endtask : rdchk

    // decoded outputs trail the register by one edge
    task automatic settle();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask : settle

    task automatic t_regs();
        rdchk("rstwdt_word", `CWDEC_OFS_RSTWDT, 16'h3fef);
        rdchk("prot_word", `CWDEC_OFS_PROT, 16'h2f9f);
        rdchk("codeprot_word", `CWDEC_OFS_CODEPROT, 16'h0003);
        i_prog.wr_word(`CWDEC_OFS_RSVD, 16'hffff);
        rdchk("reserved_word", `CWDEC_OFS_RSVD, 16'h0000);
        i_prog.wr_word(16'h8020, 16'hffff);
        rdchk("unmapped", 16'h8020, 16'h0000);
    endtask : t_regs

    // k[0] software enables, k[1] sleep, k[2] level and reset-pin bits
    task automatic t_modes();
        logic [15:0] w;
        logic e;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 8; k++) begin
                w = 16'h3c00 | 16'(k[2]) << 9 | 16'(m) << 6 | 16'(m) << 3 | 16'(m) << 1 | 16'(k[2]);
                i_prog.wr_word(`CWDEC_OFS_CTRL, {14'h0000, k[0] == 1, k[0] == 1});
                i_sleep <= k[1];
                i_prog.wr_word(`CWDEC_OFS_RSTWDT, w);
                settle();
                e = (m == 3) || (m == 2 && k[1] == 0) || (m == 1 && k[0] == 1);
                chk("brownout_en", 32'(bor), 32'(e));
                chk("brownout_level", 32'(blvl), 32'(k[2]));
                chk("watchdog_en", 32'(wdt), 32'(e));
                chk("powerup_en", 32'(pwen), 32'(m != 3));
                if (m != 3) begin
                    chk("powerup_cycles", pcyc, 32'((m == 2 ? 64 : m == 1 ? 16 : 1) * KHZ));
                end
                chk("pin_is_reset", 32'(pin_rst), 32'h1);
            end
        end
    endtask : t_modes

    task automatic t_pin();
        @(posedge i_core_clk);
        i_lowv_prog_active <= 1'b1;
        i_prog.wr_word(`CWDEC_OFS_PROT, 16'h0f9f);
        rdchk("lowv_kept", `CWDEC_OFS_PROT, 16'h2f9f);
        @(posedge i_core_clk);
        i_lowv_prog_active <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            i_prog.wr_word(`CWDEC_OFS_PROT, 16'h0f9f | 16'(n[1]) << 13);
            i_prog.wr_word(`CWDEC_OFS_RSTWDT, 16'h3fee | 16'(n[0]));
            settle();
            chk("pin_is_reset", 32'(pin_rst), 32'(n != 0));
        end
    endtask : t_pin

    task automatic t_protect();
        logic [14:0] e;
        i_prog.wr_word(`CWDEC_OFS_PROT, 16'h201f);
        settle();
        chk("write_protect", 32'(wp), 32'h0d);
        i_prog.wr_word(`CWDEC_OFS_PROT, 16'h2f9c);
        rdchk("protect_sticky", `CWDEC_OFS_PROT, 16'h201c);
        i_prog.wr_word(`CWDEC_OFS_PROT, 16'h2004);
        settle();
        chk("write_protect", 32'(wp), 32'h1f);
        chk("regions_en", 32'({store_en, bb_en}), 32'h3);
        chk("boot_end", 32'(bend), 32'h0fff);
        i_prog.wr_word(`CWDEC_OFS_PROT, 16'h2007);
        rdchk("boot_size_locked", `CWDEC_OFS_PROT, 16'h2004);
        for (int c = 0; c < 8; c++) begin
            i_prog.wr_word(`CWDEC_OFS_ERASE, `CWDEC_ERASE_KEY);
            rdchk("erased_prot", `CWDEC_OFS_PROT, 16'h2f9f);
            i_prog.wr_word(`CWDEC_OFS_PROT, 16'h2f98 | 16'(c));
            i_prog.wr_word(`CWDEC_OFS_PROT, 16'h2f90 | 16'(c));
            settle();
            e = c == 7 ? 15'h01ff : c == 6 ? 15'h03ff : c == 5 ? 15'h07ff :
                c == 4 ? 15'h0fff : c == 3 ? 15'h1fff : 15'h3fff;
            if (e > 15'(FLASH / 2 - 1)) begin
                e = 15'(FLASH / 2 - 1);
            end
            chk("boot_end", 32'(bend), 32'(e));
            chk("boot_en", 32'(bb_en), 32'h1);
        end
    endtask : t_protect

    task automatic t_code();
        @(posedge i_core_clk);
        i_ext_rd_data <= 14'h2abc;
        i_prog.program_all(16'h3fef, 16'h2f9f, 16'h0002);
        settle();
        chk("flash_protect", 32'({fcp, ecp}), 32'h2);
        chk("prog_block", 32'(pblk), 32'h1);
        chk("ext_rd_data", 32'(xrd), 32'h0);
        rdchk("status", `CWDEC_OFS_STAT, 16'h0023);
        i_prog.wr_word(`CWDEC_OFS_CODEPROT, 16'h0000);
        settle();
        chk("eeprom_protect", 32'(ecp), 32'h1);
        i_prog.wr_word(`CWDEC_OFS_CODEPROT, 16'h0003);
        rdchk("codeprot_sticky", `CWDEC_OFS_CODEPROT, 16'h0000);
        i_prog.wr_word(`CWDEC_OFS_ERASE, `CWDEC_ERASE_KEY);
        settle();
        chk("protect_cleared", 32'({fcp, ecp, pblk}), 32'h0);
        chk("ext_rd_data", 32'(xrd), 32'h2abc);
        i_prog.wr_word(`CWDEC_OFS_CODEPROT, 16'h0001);
        settle();
        chk("eeprom_only", 32'({fcp, ecp}), 32'h1);
        chk("ext_rd_data", 32'(xrd), 32'h2abc);
    endtask : t_code

    initial begin
        i_reset = 1'b1;
        i_sleep = 1'b0;
        i_lowv_prog_active = 1'b0;
        i_ext_rd_data = 14'h0000;
        repeat (3) @(posedge i_core_clk);
        i_reset <= 1'b0;
        t_regs();
        t_modes();
        t_pin();
        t_protect();
        t_code();
        finish_test();
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_fail++;
        finish_test();
    end
endmodule : tb_config_word_decoder
